// [verilog/liu_control_register_map.sv]
/*
 * Register bank of a dual channel line interface, reached over a four
 * wire serial control port, plus the per-channel transmit interrupts.
 * Assumes the serial pins and clock-select pins are asynchronous to
 * core_clk, which must run at least five times the serial clock rate.
 */
`timescale 1ns/10ps
module liu_control_register_map (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // serial control port pins
  input  wire logic                  serial_port_enable,
  input  wire logic                  serial_port_clock,
  input  wire logic                  serial_port_din,
  output logic                       serial_port_dout,
  output logic                       serial_port_dout_oe,
  // reference clock select strap
  input  wire logic            [1:0] refclk_sel_pin,
  // channel events
  input  wire logic            [1:0] rx_signal_loss,
  input  wire logic            [1:0] rx_lock_loss,
  input  wire logic            [1:0] tx_lock_loss,
  input  wire logic            [1:0] fifo_error_flag,
  // global configuration
  output logic                       low_line_rate_sel,
  output logic                       nibble_if_sel,
  output logic                 [1:0] refclk_freq_sel,
  // channel configuration, channel 1 in the upper byte
  output logic                [15:0] chan_mode_reg,
  output logic                [15:0] chan_signal_reg,
  output logic                [15:0] adv_tx_reg_one,
  output logic                [15:0] adv_tx_reg_zero,
  output logic                [15:0] chan_mode_reg_two,
  // transmit interrupts
  output logic                 [1:0] tx_irq_out
);
  import liu_regs_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [3:1] sync_a;
  logic [3:1] sync_b;
  logic [1:0] strap_a;
  logic [1:0] strap_b;
  logic       sclk_prev;
  logic       sclk_rise;
  logic       sclk_fall;

  // two flops for every serial port and strap pin
  always_ff @(posedge core_clk) begin
    sync_a  <= {serial_port_enable, serial_port_clock, serial_port_din};
    sync_b  <= sync_a;
    strap_a <= refclk_sel_pin;
    strap_b <= strap_a;
  end

  // serial clock edge detect
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sync_b[2];
    end
  end

  assign sclk_rise = sync_b[3] & sync_b[2] & ~sclk_prev;
  assign sclk_fall = sync_b[3] & ~sync_b[2] & sclk_prev;

  // ==========================================================
  // register storage
  logic [7:0] master_ctrl_reg;
  logic [7:0] irq_ctrl_reg;
  logic [7:0] glob_rsv_reg;
  logic [7:0] chan_regs [CHAN_COUNT][CHAN_REGS];
  logic [7:0] status_byte [CHAN_COUNT];
  logic       soft_pending;
  logic       wr_strobe;
  logic [3:0] wr_port;
  logic [2:0] wr_sub;
  logic [7:0] wr_data;
  logic [1:0] status_clear;

  // port address valid for any access
  function automatic logic port_valid(input logic [3:0] port);
    port_valid = (port <= PORT_LAST);
  endfunction : port_valid

  // read multiplexer over the whole map
  function automatic logic [7:0] reg_value(
    input logic [3:0] port,
    input logic [2:0] sub
  );
    int ch;
    reg_value = 8'h00;
    ch = (port == 4'h2) ? 1 : 0;
    if (port == PORT_GLOBAL) begin
      case (sub)
        SUB_MASTER:   reg_value = master_ctrl_reg;
        SUB_IRQ:      reg_value = irq_ctrl_reg;
        SUB_GLOB_RSV: reg_value = glob_rsv_reg;
        default:      reg_value = 8'h00;
      endcase
    end else if (port_valid(port)) begin
      if (sub == SUB_STATUS) begin
        reg_value = status_byte[ch];
      end else if (sub < SUB_STATUS) begin
        reg_value = chan_regs[ch][sub];
      end
    end
  endfunction : reg_value

  // ==========================================================
  // global registers
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_pending) begin
      master_ctrl_reg <= MASTER_RST;
      master_ctrl_reg[REFCLK_LSB +: 2] <= strap_b;
      irq_ctrl_reg    <= IRQ_RST;
      glob_rsv_reg    <= GLOB_RSV_RST;
    end else if (wr_strobe && wr_port == PORT_GLOBAL) begin
      case (wr_sub)
        SUB_MASTER:   master_ctrl_reg <= wr_data;
        SUB_IRQ:      irq_ctrl_reg    <= wr_data;
        SUB_GLOB_RSV: glob_rsv_reg    <= wr_data;
        default:      glob_rsv_reg    <= glob_rsv_reg;
      endcase
    end
  end

  // soft reset request, one cycle then defaults
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_pending) begin
      soft_pending <= 1'b0;
    end else begin
      soft_pending <= wr_strobe && wr_port == PORT_GLOBAL && wr_sub == SUB_MASTER && wr_data[SOFT_RESET_BIT];
    end
  end

  // ==========================================================
  // per-channel registers and status
  genvar g;
  generate
    for (g = 0; g < CHAN_COUNT; g++) begin : gen_chan
      // control registers of one channel
      always_ff @(posedge core_clk) begin
        if (!reset_n || soft_pending) begin
          chan_regs[g][SUB_MODE]     <= MODE_RST;
          chan_regs[g][SUB_SIGNAL]   <= SIGNAL_RST;
          chan_regs[g][SUB_ADV_ONE]  <= ADV_ONE_RST;
          chan_regs[g][SUB_ADV_ZERO] <= ADV_ZERO_RST;
          chan_regs[g][SUB_MODE_TWO] <= MODE_TWO_RST;
        end else if (wr_strobe && wr_port == 4'(g + 1) && wr_sub < SUB_STATUS) begin
          chan_regs[g][wr_sub] <= wr_data;
        end
      end

      chan_status_flags u_flags (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .rx_signal_loss  (rx_signal_loss[g]),
        .rx_lock_loss    (rx_lock_loss[g]),
        .tx_lock_loss    (tx_lock_loss[g]),
        .fifo_error_flag (fifo_error_flag[g]),
        .read_clear      (status_clear[g]),
        .soft_clear      (soft_pending),
        .status_byte     (status_byte[g])
      );

      // transmit interrupt, any passed source asserts it
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          tx_irq_out[g] <= 1'b1;
        end else begin
          tx_irq_out[g] <= irq_ctrl_reg[IRQ_POL_BIT] ~^
            ((status_byte[g][STATUS_TX_LOL] & irq_ctrl_reg[TX_LOCK_PASS]) |
             (status_byte[g][STATUS_FIFO] & irq_ctrl_reg[FIFO_ERR_PASS]));
        end
      end

      // configuration outputs
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          chan_mode_reg[8*g +: 8]     <= MODE_RST;
          chan_signal_reg[8*g +: 8]   <= SIGNAL_RST;
          adv_tx_reg_one[8*g +: 8]    <= ADV_ONE_RST;
          adv_tx_reg_zero[8*g +: 8]   <= ADV_ZERO_RST;
          chan_mode_reg_two[8*g +: 8] <= MODE_TWO_RST;
        end else begin
          chan_mode_reg[8*g +: 8]     <= chan_regs[g][SUB_MODE];
          chan_signal_reg[8*g +: 8]   <= chan_regs[g][SUB_SIGNAL];
          adv_tx_reg_one[8*g +: 8]    <= chan_regs[g][SUB_ADV_ONE];
          adv_tx_reg_zero[8*g +: 8]   <= chan_regs[g][SUB_ADV_ZERO];
          chan_mode_reg_two[8*g +: 8] <= chan_regs[g][SUB_MODE_TWO];
        end
      end
    end
  endgenerate

  // global configuration outputs
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_line_rate_sel <= 1'b0;
      nibble_if_sel     <= 1'b0;
      refclk_freq_sel   <= 2'h0;
    end else begin
      low_line_rate_sel <= master_ctrl_reg[LINE_RATE_BIT];
      nibble_if_sel     <= master_ctrl_reg[NIBBLE_IF_BIT];
      refclk_freq_sel   <= master_ctrl_reg[REFCLK_LSB +: 2];
    end
  end

  // ==========================================================
  // serial frame engine
  logic [4:0] bit_count;
  logic [7:0] addr_shift;
  logic [7:0] data_shift;
  logic [7:0] read_shift;
  logic [7:0] next_addr;
  logic       is_read;

  assign next_addr = {sync_b[1], addr_shift[7:1]};

  // bit counter and input shift, frame restarts on enable low
  always_ff @(posedge core_clk) begin
    if (!reset_n || !sync_b[3]) begin
      bit_count  <= 5'h00;
      addr_shift <= 8'h00;
      data_shift <= 8'h00;
    end else if (sclk_rise && bit_count < 5'(FRAME_BITS)) begin
      bit_count <= bit_count + 5'h01;
      if (bit_count < 5'(BYTE_W)) begin
        addr_shift <= next_addr;
      end else begin
        data_shift <= {sync_b[1], data_shift[7:1]};
      end
    end
  end

  // read flag and read data load at end of address byte
  always_ff @(posedge core_clk) begin
    if (!reset_n || !sync_b[3]) begin
      is_read    <= 1'b0;
      read_shift <= 8'h00;
      status_clear <= 2'h0;
    end else begin
      status_clear <= 2'h0;
      if (sclk_rise && bit_count == 5'(BYTE_W - 1)) begin
        is_read <= next_addr[RW_BIT] && port_valid(next_addr[PORT_LSB +: PORT_W]);
        if (next_addr[RW_BIT]) begin
          read_shift <= reg_value(next_addr[PORT_LSB +: PORT_W], next_addr[SUB_LSB +: SUB_W]);
          if (next_addr[SUB_LSB +: SUB_W] == SUB_STATUS) begin
            status_clear[0] <= next_addr[PORT_LSB +: PORT_W] == 4'h1;
            status_clear[1] <= next_addr[PORT_LSB +: PORT_W] == 4'h2;
          end
        end
      end else if (sclk_fall && is_read && bit_count >= 5'(BYTE_W)) begin
        read_shift <= {1'b0, read_shift[7:1]};
      end
    end
  end

  // write commit on the last data bit
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_strobe <= 1'b0;
      wr_port   <= 4'h0;
      wr_sub    <= 3'h0;
      wr_data   <= 8'h00;
    end else begin
      wr_strobe <= sync_b[3] && sclk_rise && bit_count == 5'(FRAME_BITS - 1) &&
                   !addr_shift[RW_BIT] && port_valid(addr_shift[PORT_LSB +: PORT_W]);
      wr_port   <= addr_shift[PORT_LSB +: PORT_W];
      wr_sub    <= addr_shift[SUB_LSB +: SUB_W];
      wr_data   <= {sync_b[1], data_shift[7:1]};
    end
  end

  // data out driven only while read data shifts
  always_ff @(posedge core_clk) begin
    if (!reset_n || !sync_b[3]) begin
      serial_port_dout    <= 1'b0;
      serial_port_dout_oe <= 1'b0;
    end else if (sclk_fall) begin
      if (is_read && bit_count >= 5'(BYTE_W) && bit_count < 5'(FRAME_BITS)) begin
        serial_port_dout    <= read_shift[0];
        serial_port_dout_oe <= 1'b1;
      end else begin
        serial_port_dout_oe <= 1'b0;
      end
    end
  end

endmodule : liu_control_register_map

// [verilog/liu_regs_pkg.sv]
/*
 * Constants shared by the line interface register bank: address byte
 * layout, port and sub-address decode, field positions and reset values.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package liu_regs_pkg;

  // ==========================================================
  // address byte layout
  localparam int RW_BIT         = 0;
  localparam int SUB_LSB        = 1;
  localparam int SUB_W          = 3;
  localparam int PORT_LSB       = 4;
  localparam int PORT_W         = 4;
  localparam int BYTE_W         = 8;
  localparam int FRAME_BITS     = 16;
  localparam int CHAN_COUNT     = 2;
  localparam int CHAN_REGS      = 5;

  // ==========================================================
  // port addresses
  localparam logic [3:0] PORT_GLOBAL = 4'h0;
  localparam logic [3:0] PORT_LAST   = 4'h2;

  // ==========================================================
  // global sub-addresses
  localparam logic [2:0] SUB_MASTER   = 3'h0;
  localparam logic [2:0] SUB_IRQ      = 3'h1;
  localparam logic [2:0] SUB_GLOB_RSV = 3'h2;

  // ==========================================================
  // per-channel sub-addresses
  localparam logic [2:0] SUB_MODE     = 3'h0;
  localparam logic [2:0] SUB_SIGNAL   = 3'h1;
  localparam logic [2:0] SUB_ADV_ONE  = 3'h2;
  localparam logic [2:0] SUB_ADV_ZERO = 3'h3;
  localparam logic [2:0] SUB_MODE_TWO = 3'h4;
  localparam logic [2:0] SUB_STATUS   = 3'h5;

  // ==========================================================
  // master control fields
  localparam int LINE_RATE_BIT  = 7;
  localparam int NIBBLE_IF_BIT  = 5;
  localparam int REFCLK_LSB     = 3;
  localparam int SOFT_RESET_BIT = 0;

  // ==========================================================
  // interrupt control fields
  localparam int IRQ_POL_BIT    = 7;
  localparam int TX_LOCK_PASS   = 1;
  localparam int FIFO_ERR_PASS  = 0;

  // ==========================================================
  // status monitor fields
  localparam int STATUS_RX_LOS  = 4;
  localparam int STATUS_RX_LOL  = 3;
  localparam int STATUS_TX_LOL  = 1;
  localparam int STATUS_FIFO    = 0;

  // ==========================================================
  // reset values (refclk field is filled from the pin)
  localparam logic [7:0] MASTER_RST   = 8'h00;
  localparam logic [7:0] IRQ_RST      = 8'h23;
  localparam logic [7:0] GLOB_RSV_RST = 8'h00;
  localparam logic [7:0] MODE_RST     = 8'h01;
  localparam logic [7:0] SIGNAL_RST   = 8'h00;
  localparam logic [7:0] ADV_ONE_RST  = 8'h00;
  localparam logic [7:0] ADV_ZERO_RST = 8'hA8;
  localparam logic [7:0] MODE_TWO_RST = 8'h80;

  // ==========================================================
  // serial clock limit
  localparam int CORE_CLK_MHZ      = 100;
  localparam int SCLK_MAX_MHZ      = 20;
  localparam int SCLK_PERIOD_CYCLES = CORE_CLK_MHZ / SCLK_MAX_MHZ;

endpackage : liu_regs_pkg

// [verilog/chan_status_flags.sv]
/*
 * Sticky status flags of one channel, cleared by a read of the status
 * register. Assumes the event inputs are on core_clk.
 */
`timescale 1ns/10ps
module chan_status_flags (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // events from the channel
  input  wire logic       rx_signal_loss,
  input  wire logic       rx_lock_loss,
  input  wire logic       tx_lock_loss,
  input  wire logic       fifo_error_flag,
  // clear on read, soft reset
  input  wire logic       read_clear,
  input  wire logic       soft_clear,
  // status byte
  output logic      [7:0] status_byte
);
  import liu_regs_pkg::*;

  logic [7:0] events;

  // events placed at their status positions
  always_comb begin
    events                = 8'h00;
    events[STATUS_RX_LOS] = rx_signal_loss;
    events[STATUS_RX_LOL] = rx_lock_loss;
    events[STATUS_TX_LOL] = tx_lock_loss;
    events[STATUS_FIFO]   = fifo_error_flag;
  end

  // sticky flags, a new event wins over the read clear; soft clear drops it
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_clear) begin
      status_byte <= 8'h00;
    end else if (read_clear) begin
      status_byte <= events;
    end else begin
      status_byte <= status_byte | events;
    end
  end

endmodule : chan_status_flags

// [tb/liu_regs_sva.sv]
/*
 * Checker for the register bank: reset values, serial read timing and
 * idle behaviour. Assumes an 80 ns serial clock; bound to the top module.
 */
`timescale 1ns/10ps
module liu_regs_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // serial port
  input wire logic        serial_port_enable,
  input wire logic        serial_port_clock,
  input wire logic        serial_port_dout,
  input wire logic        serial_port_dout_oe,
  // configuration and interrupts
  input wire logic  [1:0] refclk_sel_pin,
  input wire logic        low_line_rate_sel,
  input wire logic        nibble_if_sel,
  input wire logic  [1:0] refclk_freq_sel,
  input wire logic [15:0] chan_mode_reg,
  input wire logic [15:0] chan_signal_reg,
  input wire logic [15:0] adv_tx_reg_one,
  input wire logic [15:0] adv_tx_reg_zero,
  input wire logic [15:0] chan_mode_reg_two,
  input wire logic  [1:0] tx_irq_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ====================
  // values right after reset
  a_reset_pins: assert property (
    $rose(reset_n) |-> !serial_port_dout_oe && tx_irq_out == 2'h3) else $error("bad dout enable or irq at reset");
  a_master_dflt: assert property (
    $rose(reset_n) |-> !low_line_rate_sel && !nibble_if_sel) else $error("bad master default");
  a_refclk_strap: assert property (
    $rose(reset_n) |=> refclk_freq_sel == refclk_sel_pin) else $error("refclk field not from strap");
  a_chan_dflt: assert property (
    $rose(reset_n) |-> chan_mode_reg == 16'h0101 && adv_tx_reg_zero == 16'hA8A8 && chan_mode_reg_two == 16'h8080
      && chan_signal_reg == 16'h0000 && adv_tx_reg_one == 16'h0000) else $error("bad channel default");
  // ====================
  // serial port behaviour
  a_oe_idle_off: assert property (
    !serial_port_enable [*8] |-> !serial_port_dout_oe) else $error("dout driven outside a frame");
  a_oe_span: assert property (
    $rose(serial_port_dout_oe) |-> (serial_port_enable && serial_port_dout_oe) [*8]) else $error("short read bit");
  a_dout_hold: assert property (
    serial_port_dout_oe && $rose(serial_port_clock) |-> ##2 $stable(serial_port_dout) [*3])
    else $error("dout moved near rising clock");
  a_cfg_hold_idle: assert property (
    !serial_port_enable [*8] |-> $stable({chan_signal_reg, adv_tx_reg_one, nibble_if_sel}))
    else $error("configuration changed while idle");
  // main scenarios reached
  c_read: cover property ($rose(serial_port_dout_oe));
  c_irq_high: cover property (tx_irq_out == 2'h1);
  c_write: cover property ($changed(chan_signal_reg));
endmodule : liu_regs_sva

bind liu_control_register_map liu_regs_sva u_sva (
  .core_clk(core_clk), .reset_n(reset_n), .serial_port_enable(serial_port_enable),
  .serial_port_clock(serial_port_clock), .serial_port_dout(serial_port_dout),
  .serial_port_dout_oe(serial_port_dout_oe), .refclk_sel_pin(refclk_sel_pin),
  .low_line_rate_sel(low_line_rate_sel), .nibble_if_sel(nibble_if_sel), .refclk_freq_sel(refclk_freq_sel),
  .chan_mode_reg(chan_mode_reg), .chan_signal_reg(chan_signal_reg), .adv_tx_reg_one(adv_tx_reg_one),
  .adv_tx_reg_zero(adv_tx_reg_zero), .chan_mode_reg_two(chan_mode_reg_two), .tx_irq_out(tx_irq_out));

// [tb/serial_host_model.sv]
/*
 * Controller model for the serial control port: frames of an address
 * byte and a data byte. Assumes callers run from core_clk time steps.
 */
`timescale 1ns/10ps
module serial_host_model (
  // timing reference
  input  wire logic core_clk,
  // serial port lines
  output logic      serial_port_enable,
  output logic      serial_port_clock,
  output logic      serial_port_din,
  input  wire logic serial_port_dout,
  input  wire logic serial_port_dout_oe
);
  // lines idle, clock parked low between frames
  initial begin
    serial_port_enable = 1'b0;
    serial_port_clock  = 1'b0;
    serial_port_din    = 1'b0;
  end

  // half of an 80 ns serial clock period
  task half;
    repeat (4) @(negedge core_clk);
  endtask : half

  // one access, lsb first; oe_bits marks where dout was driven
  task automatic frame(input logic [7:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata, output logic [7:0] oe_bits);
    logic [15:0] bits;
    bits    = {wdata, addr};
    rdata   = 8'h00;
    oe_bits = 8'h00;
    @(negedge core_clk);
    serial_port_enable = 1'b1;
    for (int i = 0; i < 16; i++) begin
      serial_port_din = bits[i];
      half();
      serial_port_clock = 1'b1;
      half();
      if (i > 7) begin
        rdata[i-8]   = serial_port_dout_oe ? serial_port_dout : 1'b1; // released line pulled up
        oe_bits[i-8] = serial_port_dout_oe;
      end
      serial_port_clock = 1'b0;
    end
    half();
    serial_port_enable = 1'b0;
    serial_port_din    = ~serial_port_din; // no stale bit after release
    half();
  endtask : frame
endmodule : serial_host_model

// [tb/testbench.sv]
/*
 * Self-checking bench for the register bank.
 * Assumes the serial host model and the bound checker.
 */
`timescale 1ns/10ps
module testbench;
  import liu_regs_pkg::*;
  // ====================
  // pins and bookkeeping
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        serial_port_enable, serial_port_clock, serial_port_din, serial_port_dout, serial_port_dout_oe;
  logic  [1:0] refclk_sel_pin = 2'h3;
  logic  [1:0] rx_signal_loss = 2'h0, rx_lock_loss = 2'h0, tx_lock_loss = 2'h0, fifo_error_flag = 2'h0;
  logic        low_line_rate_sel, nibble_if_sel;
  logic  [1:0] refclk_freq_sel, tx_irq_out;
  logic [15:0] chan_mode_reg, chan_signal_reg, adv_tx_reg_one, adv_tx_reg_zero, chan_mode_reg_two;
  logic  [7:0] rd_data, oe_bits;
  int          mismatches = 0;
  int          n_compared = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // device and controller
  liu_control_register_map u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .serial_port_enable(serial_port_enable), .serial_port_clock(serial_port_clock),
    .serial_port_din(serial_port_din), .serial_port_dout(serial_port_dout),
    .serial_port_dout_oe(serial_port_dout_oe), .refclk_sel_pin(refclk_sel_pin),
    .rx_signal_loss(rx_signal_loss), .rx_lock_loss(rx_lock_loss), .tx_lock_loss(tx_lock_loss),
    .fifo_error_flag(fifo_error_flag), .low_line_rate_sel(low_line_rate_sel), .nibble_if_sel(nibble_if_sel),
    .refclk_freq_sel(refclk_freq_sel), .chan_mode_reg(chan_mode_reg), .chan_signal_reg(chan_signal_reg),
    .adv_tx_reg_one(adv_tx_reg_one), .adv_tx_reg_zero(adv_tx_reg_zero),
    .chan_mode_reg_two(chan_mode_reg_two), .tx_irq_out(tx_irq_out));
  serial_host_model u_host (.core_clk(core_clk), .serial_port_enable(serial_port_enable),
    .serial_port_clock(serial_port_clock), .serial_port_din(serial_port_din),
    .serial_port_dout(serial_port_dout), .serial_port_dout_oe(serial_port_dout_oe));

  // ====================
  // helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] p, input logic [2:0] s, input logic [7:0] d);
    u_host.frame({p, s, 1'b0}, d, rd_data, oe_bits);
  endtask : wr
  task rd(input logic [3:0] p, input logic [2:0] s);
    u_host.frame({p, s, 1'b1}, 8'h00, rd_data, oe_bits);
  endtask : rd
  // one-cycle event pulse, bits rx_signal, rx_lock, tx_lock, fifo by channel
  task ev(input logic [7:0] v);
    @(negedge core_clk);
    {rx_signal_loss, rx_lock_loss, tx_lock_loss, fifo_error_flag} = v;
    @(negedge core_clk);
    {rx_signal_loss, rx_lock_loss, tx_lock_loss, fifo_error_flag} = 8'h00;
    repeat (3) @(negedge core_clk);
  endtask : ev
  task do_reset(input logic [1:0] strap);
    @(negedge core_clk);
    reset_n        = 1'b0;
    refclk_sel_pin = strap;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask : do_reset

  // ====================
  // scenarios
  task t_defaults;
    logic [7:0] dflt [0:6];
    dflt = '{8'h01, 8'h00, 8'h00, 8'hA8, 8'h80, 8'h00, 8'h00};
    rd(4'h0, 3'h0);
    chk({oe_bits, rd_data}, 16'hFF18);
    rd(4'h0, 3'h1);
    chk({oe_bits, rd_data}, 16'hFF23);
    for (int p = 1; p <= 2; p++) begin
      for (int s = 0; s <= 6; s++) begin
        rd(p[3:0], s[2:0]);
        chk({oe_bits, rd_data}, {8'hFF, dflt[s]});
      end
    end
    $display("t_defaults done");
  endtask : t_defaults
  task t_write;
    logic [1:0] codes [0:2];
    codes = '{2'h3, 2'h2, 2'h0};
    for (int p = 1; p <= 2; p++) begin
      for (int s = 0; s <= 4; s++) begin
        wr(p[3:0], s[2:0], {p[1:0], 3'h2, s[2:0]});
        rd(p[3:0], s[2:0]);
        chk({oe_bits, rd_data}, {8'hFF, p[1:0], 3'h2, s[2:0]});
      end
    end
    chk(chan_mode_reg, 16'h9050);
    chk(chan_signal_reg, 16'h9151);
    chk(adv_tx_reg_one, 16'h9252);
    chk(adv_tx_reg_zero, 16'h9353);
    chk(chan_mode_reg_two, 16'h9454);
    wr(4'h0, 3'h2, 8'h5E);
    rd(4'h0, 3'h2);
    chk({oe_bits, rd_data}, 16'hFF5E);
    for (int c = 0; c < 3; c++) begin
      wr(4'h0, 3'h0, {3'h5, codes[c], 3'h0});
      chk({12'h000, low_line_rate_sel, nibble_if_sel, refclk_freq_sel}, {14'h0003, codes[c]});
    end
    $display("t_write done");
  endtask : t_write
  task t_invalid;
    logic [3:0] bad [0:2];
    bad = '{4'h3, 4'h8, 4'hF};
    for (int i = 0; i < 3; i++) begin
      wr(bad[i], 3'h0, 8'h01);
      wr(bad[i], 3'h1, 8'h00);
      rd(bad[i], 3'h0);
      chk({oe_bits, rd_data}, 16'h00FF);
    end
    chk(chan_signal_reg, 16'h9151);
    chk({14'h0000, low_line_rate_sel, nibble_if_sel}, 16'h0003);
    $display("t_invalid done");
  endtask : t_invalid
  task t_soft;
    wr(4'h0, 3'h0, 8'hA1);
    chk({14'h0000, low_line_rate_sel, nibble_if_sel}, 16'h0000);
    chk(chan_mode_reg, 16'h0101);
    rd(4'h0, 3'h0);
    chk({oe_bits, rd_data}, 16'hFF18);
    rd(4'h0, 3'h2);
    chk({oe_bits, rd_data}, 16'hFF00);
    $display("t_soft done");
  endtask : t_soft
  task t_irq;
    chk({14'h0000, tx_irq_out}, 16'h0003);
    ev(8'h01);
    chk({14'h0000, tx_irq_out}, 16'h0002);
    wr(4'h0, 3'h1, 8'h81);
    ev(8'h04);
    chk({14'h0000, tx_irq_out}, 16'h0001);
    wr(4'h0, 3'h1, 8'h82);
    chk({14'h0000, tx_irq_out}, 16'h0001);
    wr(4'h0, 3'h1, 8'h80);
    ev(8'hAA);
    chk({14'h0000, tx_irq_out}, 16'h0000);
    wr(4'h0, 3'h1, 8'h83);
    rd(4'h3, 3'h5);
    chk({14'h0000, tx_irq_out}, 16'h0003);
    rd(4'h1, 3'h5);
    chk({oe_bits, rd_data}, 16'hFF03);
    chk({14'h0000, tx_irq_out}, 16'h0002);
    rd(4'h2, 3'h5);
    chk({oe_bits, rd_data}, 16'hFF1B);
    rd(4'h2, 3'h5);
    chk({oe_bits, rd_data}, 16'hFF00);
    $display("t_irq done");
  endtask : t_irq
  task t_strap;
    do_reset(2'h2);
    rd(4'h0, 3'h0);
    chk({oe_bits, rd_data}, 16'hFF10);
    $display("t_strap done");
  endtask : t_strap

  // verdict and end of run
  task results;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // main sequence
  initial begin
    do_reset(2'h3);
    t_defaults;
    t_write;
    t_invalid;
    t_soft;
    t_irq;
    t_strap;
    results;
  end

  // watchdog
  initial begin
    #200000;
    mismatches++;
    results;
  end
endmodule : testbench
